// file: verilog/lvd_consts.vh
// register addresses, field positions, reset values and timing for the supply drop detector
`ifndef LVD_CONSTS_VH
`define LVD_CONSTS_VH
`define LVD_ADDR_CONTROL     16'hff50
`define LVD_ADDR_LEVEL_SEL   16'hff51
`define LVD_LEVEL_SEL_RESET  8'h00
`define LVD_CONTROL_RESET    8'h00
`define LVD_BIT_DETECTOR_ON  7
`define LVD_BIT_RESET_MODE   1
`define LVD_BIT_BELOW_FLAG   0
`define LVD_LEVEL_CODE_MAX   4'h9
`define LVD_SETTLE_TIME_NS   200000
`define LVD_CLK_PERIOD_NS    10
`define LVD_SETTLE_CYCLES    ((`LVD_SETTLE_TIME_NS + `LVD_CLK_PERIOD_NS - 1) / `LVD_CLK_PERIOD_NS)
`endif

// file: verilog/lvd_control.v
// control logic of the supply drop detector: level select, mode gating, reset cause
//
// Summary of operation
// [R1] level select register at ff51, reset to 00
// [R2] software writes level select as whole byte
// [R3] codes 0..9 select 4.3 V down to 2.35 V
// [R4] software writes zero into upper four bits
// [R5] reset mode: below level raises reset request
// [R6] interrupt mode: below level raises interrupt request
// [R7] reset start order: mask, level, on, wait, mode
// [R8] unmasked interrupt may fire right after enabling
// [R9] no reset if supply above when mode set
// [R10] stop reset mode: write 00 or ordered clears
// [R11] interrupt start: same steps, clear pending, unmask
// [R12] stop interrupt mode: write 00 or clear on
// [R13] handler checks flag, clears pending, re-enables
// [R14] detector reset sets reset cause bit 0
// [R15] interrupt only while on and not reset mode
// [R16] on/mode cleared except by own reset
// [R17] flag reads zero when disabled or above level
// [R18] comparator output passes two-stage synchroniser
`timescale 1ns/1ns
`include "lvd_consts.vh"

module lvd_control #(
	parameter SETTLE_CYCLES = `LVD_SETTLE_CYCLES
) (
	// clock and reset
	input  wire        clk_sys_in,
	input  wire        rst_in,
	input  wire        rst_by_detector_in,
	// internal bus
	input  wire [15:0] bus_addr_in,
	input  wire [7:0]  bus_wdata_in,
	input  wire        bus_wr_in,
	input  wire        bus_bit_wr_in,
	input  wire [2:0]  bus_bit_pos_in,
	input  wire        bus_bit_val_in,
	output reg  [7:0]  bus_rdata_out,
	// analogue comparator
	input  wire        cmp_below_async_in,
	output reg         cmp_enable_out,
	output reg  [3:0]  level_code_out,
	output reg         level_code_bad_out,
	// system requests
	output reg         reset_request_out,
	output reg         low_supply_irq_out,
	output reg         low_supply_reset_cause_out,
	input  wire        reset_cause_clear_in,
	output reg         settled_out
);

	reg        detector_on;
	reg        reset_mode_select;
	reg [3:0]  detect_level_select;
	reg        cmp_meta;
	reg        cmp_sync;
	reg [17:0] settle_cnt;
	reg [7:0]  next_control;
	wire       below_level_flag;
	wire       sel_control;
	wire       sel_level;
	wire       sel_control_byte;
	wire       sel_control_bit;
	wire       sel_level_byte;
	wire       next_reset_request;
	wire       next_irq_request;
	wire       settle_last;

	// reset values and limits taken into sized constants once
	localparam [7:0]  LEVEL_RESET   = `LVD_LEVEL_SEL_RESET;
	localparam [7:0]  CONTROL_RESET = `LVD_CONTROL_RESET;
	localparam [3:0]  LEVEL_MAX     = `LVD_LEVEL_CODE_MAX;
	localparam [15:0] ADDR_CONTROL  = `LVD_ADDR_CONTROL;
	localparam [15:0] ADDR_LEVEL    = `LVD_ADDR_LEVEL_SEL;

	// full 16-bit compare, shared by both register selects
	function addr_hit;
		input [15:0] addr;
		input [15:0] target;
		begin
			addr_hit = (addr == target);
		end
	endfunction

	// codes above nine leave the comparator threshold undefined
	function code_is_bad;
		input [3:0] code;
		begin
			code_is_bad = (code > LEVEL_MAX);
		end
	endfunction

	// control register as seen by software; bits 6 to 2 are always zero
	function [7:0] control_view;
		input on_bit;
		input mode_bit;
		input flag_bit;
		begin
			control_view = {on_bit, 5'h00, mode_bit, flag_bit};
		end
	endfunction

	assign sel_control        = addr_hit(bus_addr_in, ADDR_CONTROL);
	assign sel_level          = addr_hit(bus_addr_in, ADDR_LEVEL);
	assign sel_control_byte   = sel_control & bus_wr_in;
	assign sel_control_bit    = sel_control & bus_bit_wr_in;
	// a bit access to the level register is refused; only byte writes land
	assign sel_level_byte     = sel_level & bus_wr_in;
	assign below_level_flag   = detector_on & cmp_sync; // see [R17]

	// mode selects which request the gated flag feeds; never both at once
	assign next_reset_request = reset_mode_select & below_level_flag;
	assign next_irq_request   = ~reset_mode_select & below_level_flag;
	assign settle_last        = (settle_cnt >= SETTLE_CYCLES[17:0] - 18'h00001);

	// the comparator is analogue and free running, its edges unrelated to the clock
	// second stage only feeds the logic; first stage is read by nothing else
	always @(posedge clk_sys_in) begin
		cmp_meta <= cmp_below_async_in; // see [R18]
		cmp_sync <= cmp_meta;           // see [R18]
	end

	// byte write or single-bit write to the control register
	always @* begin
		next_control = control_view(detector_on, reset_mode_select, 1'b0);
		if (sel_control_byte) begin
			next_control = bus_wdata_in;
		end else if (sel_control_bit) begin
			next_control[bus_bit_pos_in] = bus_bit_val_in;
		end
	end

	// own reset keeps enable and mode; any other reset clears them
	always @(posedge clk_sys_in) begin
		if (rst_in) begin
			if (!rst_by_detector_in) begin
				detector_on       <= CONTROL_RESET[`LVD_BIT_DETECTOR_ON]; // see [R16]
				reset_mode_select <= CONTROL_RESET[`LVD_BIT_RESET_MODE];  // see [R16]
			end
		end else begin
			detector_on       <= next_control[`LVD_BIT_DETECTOR_ON];
			reset_mode_select <= next_control[`LVD_BIT_RESET_MODE];
		end
	end

	// only byte writes load the level; upper bits are not stored
	always @(posedge clk_sys_in) begin
		if (rst_in) begin
			detect_level_select <= LEVEL_RESET[3:0]; // see [R1]
		end else if (sel_level_byte) begin
			detect_level_select <= bus_wdata_in[3:0]; // see [R1]
		end
	end

	// reset cause survives the detector's own reset, cleared by other resets
	// a clear strobe meeting a set is ignored: the set, made during reset, wins
	always @(posedge clk_sys_in) begin
		if (rst_in && !rst_by_detector_in) begin
			low_supply_reset_cause_out <= 1'b0;
		end else if (rst_in && rst_by_detector_in) begin
			low_supply_reset_cause_out <= 1'b1; // see [R14]
		end else if (reset_cause_clear_in) begin
			low_supply_reset_cause_out <= 1'b0;
		end
	end

	// comparator start-up time counter, informative only
	always @(posedge clk_sys_in) begin
		if (rst_in || !detector_on) begin
			settle_cnt  <= 18'h00000;
			settled_out <= 1'b0;
		end else if (settle_last) begin
			settled_out <= 1'b1;
		end else begin
			settle_cnt <= settle_cnt + 18'h00001;
		end
	end

	// requests are levels, held for as long as the gated flag stays high
	always @(posedge clk_sys_in) begin
		if (rst_in) begin
			reset_request_out  <= 1'b0;
			low_supply_irq_out <= 1'b0;
		end else begin
			// reset only follows a flag seen after mode set, so above-level gives none
			reset_request_out  <= next_reset_request; // see [R5] [R9]
			// the flag feeds the interrupt while the mode is still interrupt, so an
			// unmasked request can appear right after enabling
			low_supply_irq_out <= next_irq_request;   // see [R6] [R15] [R8]
		end
	end

	// comparator drive, registered so the pins never glitch
	always @(posedge clk_sys_in) begin
		if (rst_in) begin
			cmp_enable_out     <= 1'b0;
			level_code_out     <= LEVEL_RESET[3:0];
			level_code_bad_out <= 1'b0;
		end else begin
			cmp_enable_out     <= detector_on;
			level_code_out     <= detect_level_select; // see [R3]
			level_code_bad_out <= code_is_bad(detect_level_select); // see [R3]
		end
	end

	// read data follows the address of the previous cycle; unmapped reads give zero
	always @(posedge clk_sys_in) begin
		if (rst_in) begin
			bus_rdata_out <= 8'h00;
		end else begin
			if (sel_control) begin
				bus_rdata_out <= control_view(detector_on, reset_mode_select, below_level_flag);
			end else if (sel_level) begin
				bus_rdata_out <= {4'h0, detect_level_select}; // see [R1]
			end else begin
				bus_rdata_out <= 8'h00;
			end
		end
	end

endmodule // lvd_control

// file: test/lvd_cmp_model.sv
// comparator stand-in for the supply drop detector
`timescale 1ns/1ns
module lvd_cmp_model (
	input  wire en_in,
	input  wire drop_in,
	output wire below_out
);
	assign below_out = en_in & drop_in;
endmodule // lvd_cmp_model

// file: test/lvd_control_checker.sv
// port assertions for the supply drop detector control
`timescale 1ns/1ns
module lvd_checker (
	input wire clk_sys_in, rst_in, rst_by_detector_in, cmp_below_async_in,
	input wire cmp_enable_out, level_code_bad_out, reset_request_out,
	input wire low_supply_irq_out, low_supply_reset_cause_out,
	input wire [15:0] bus_addr_in,
	input wire [7:0]  bus_rdata_out,
	input wire [3:0]  level_code_out
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (rst_in);
	code_flag_a: assert property (level_code_bad_out == (level_code_out > 4'h9))
		else $error("prohibited code flag wrong");
	irq_gate_a: assert property (low_supply_irq_out |-> cmp_enable_out)
		else $error("irq while detector off");
	mode_excl_a: assert property (!(reset_request_out && low_supply_irq_out))
		else $error("reset and irq together");
	off_quiet_a: assert property (!cmp_enable_out && !$past(cmp_enable_out) |->
		!reset_request_out && !low_supply_irq_out) else $error("request while off");
	sync_delay_a: assert property ($rose(low_supply_irq_out) |-> $past(cmp_below_async_in, 3))
		else $error("irq ahead of synchroniser");
	rst_clear_a: assert property ($past(rst_in) && !$past(rst_by_detector_in) |->
		!cmp_enable_out && level_code_out == 4'h0) else $error("reset left state");
	cause_set_a: assert property ($past(rst_in) && $past(rst_by_detector_in) |->
		low_supply_reset_cause_out) else $error("reset cause not set");
	lvl_read_a: assert property ($past(bus_addr_in) == 16'hff51 |->
		bus_rdata_out[7:4] == 4'h0) else $error("level upper bits not zero");
	cover property (low_supply_irq_out);
	cover property (reset_request_out);
	cover property (low_supply_reset_cause_out);
endmodule // lvd_checker
bind lvd_control lvd_checker u_chk (.*);

// file: test/tb_lvd_control.sv
// bench for the supply drop detector control
`timescale 1ns/1ns
module tb_lvd_control;
	reg clk_sys_in = 0, rst_in = 1, rst_by_detector_in = 0, bus_wr_in = 0, bus_bit_wr_in = 0;
	reg bus_bit_val_in = 0, reset_cause_clear_in = 0, drop = 0;
	reg [15:0] bus_addr_in = 16'h0000;
	reg [7:0]  bus_wdata_in = 8'h00;
	reg [2:0]  bus_bit_pos_in = 3'h0;
	wire [7:0] bus_rdata_out;
	wire [3:0] level_code_out;
	wire cmp_below_async_in, cmp_enable_out, level_code_bad_out, settled_out;
	wire reset_request_out, low_supply_irq_out, low_supply_reset_cause_out;
	integer err_count = 0, total_checks = 0;
	always #5 clk_sys_in = ~clk_sys_in;
	lvd_cmp_model cm (.en_in(cmp_enable_out), .drop_in(drop), .below_out(cmp_below_async_in));
	lvd_control #(.SETTLE_CYCLES(10)) uut (.*);
	task chk(input [7:0] s, input [7:0] e);
	begin
		total_checks = total_checks + 1;
		if (s !== e) begin
			err_count = err_count + 1;
			$display("FAIL %0t got %h want %h", $time, s, e);
		end
	end
	endtask
	task n(input integer k);
		repeat (k) @(negedge clk_sys_in);
	endtask
	// bit writes carry the position in d[2:0] and the value in d[3]
	task wr(input [15:0] ad, input [7:0] d, input bitw);
	begin
		n(1);
		{bus_addr_in, bus_wdata_in, bus_bit_pos_in, bus_bit_val_in} = {ad, d, d[2:0], d[3]};
		{bus_wr_in, bus_bit_wr_in} = {!bitw, bitw};
		n(1);
		{bus_wr_in, bus_bit_wr_in} = 2'h0;
	end
	endtask
	task r(input [15:0] ad, input [7:0] e);
	begin
		n(1);
		bus_addr_in = ad;
		n(1);
		chk(bus_rdata_out, e);
	end
	endtask
	task close_out;
	begin
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	end
	endtask
	initial begin
		n(2);
		rst_in = 0;
		r(16'hff51, 8'h00);
		chk(level_code_out, 8'h00);
		wr(16'hff51, 8'h09, 0);
		r(16'hff51, 8'h09);
		wr(16'hff51, 8'h0a, 0);
		wr(16'hff51, 8'h08, 1);
		r(16'hff51, 8'h0a);
		chk(level_code_bad_out, 1);
		chk(level_code_out, 8'h0a);
		$display("level test done");
		wr(16'hff51, 8'h03, 0);
		wr(16'hff50, 8'h80, 0);
		n(12);
		chk(settled_out, 1);
		r(16'hff50, 8'h80);
		drop = 1;
		n(5);
		chk(low_supply_irq_out, 1);
		chk(reset_request_out, 0);
		r(16'hff50, 8'h81);
		drop = 0;
		n(4);
		r(16'hff50, 8'h80);
		chk(low_supply_irq_out, 0);
		wr(16'hff50, 8'h07, 1);
		n(3);
		r(16'hff50, 8'h00);
		chk(cmp_enable_out, 0);
		$display("irq test done");
		wr(16'hff50, 8'h80, 0);
		n(12);
		chk(settled_out, 1);
		r(16'hff50, 8'h80);
		wr(16'hff50, 8'h82, 0);
		n(4);
		chk(reset_request_out, 0);
		drop = 1;
		n(5);
		chk({reset_request_out, low_supply_irq_out}, 2);
		{rst_in, rst_by_detector_in} = 2'h3;
		n(2);
		{rst_in, rst_by_detector_in} = 2'h0;
		chk(low_supply_reset_cause_out, 1);
		n(3);
		r(16'hff50, 8'h83);
		chk(level_code_out, 8'h00);
		reset_cause_clear_in = 1;
		n(1);
		reset_cause_clear_in = 0;
		chk(low_supply_reset_cause_out, 0);
		wr(16'hff50, 8'h00, 0);
		n(3);
		r(16'hff50, 8'h00);
		$display("reset test done");
		close_out;
	end
	// the tests need well under a thousand cycles
	initial begin
		#50000;
		err_count = err_count + 1;
		close_out;
	end
endmodule // tb_lvd_control
